// >>> bench/pbcr_basic_control_monitor.sv
`timescale 1ns/1ps
module pbcr_basic_control_monitor #(
	parameter int SRST_CYCLES = 4
) (
	// Clock and reset
	input wire logic                   clk_sys,
	input wire logic                   rst_n,
	// Negotiation and mode
	input wire logic                   an_enable,
	input wire logic                   an_restart_pulse,
	input wire logic                   an_speed_100,
	input wire logic                   an_full_duplex,
	input wire logic                   soft_reset_active,
	input wire logic                   link_speed_100,
	input wire logic                   link_full_duplex,
	// Media-independent side, core side, line and LEDs
	input wire pbcr_pkg::pbcr_mii_tx_t mii_tx,
	input wire pbcr_pkg::pbcr_mii_rx_t mii_rx,
	input wire logic                   mii_oe_n,
	input wire pbcr_pkg::pbcr_mii_tx_t core_tx,
	input wire logic                   loop_10,
	input wire logic                   loop_100,
	input wire logic                   twisted_pair_tx_oe_n,
	input wire logic                   led_oe_n
);
	// ==========================================================================
	// Properties
	// ==========================================================================
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	int srst_run;
	always_ff @(posedge clk_sys) begin
		if (!rst_n || !soft_reset_active) srst_run <= 0;
		else srst_run <= srst_run + 1;
	end
	sequence s_loop_beat;
		(loop_10 || loop_100) && !mii_oe_n;
	endsequence
	sequence s_neg_held;
		$past(an_enable) && an_enable;
	endsequence
	property p_loop_echo;
		s_loop_beat |-> mii_rx.rx_dv == $past(mii_tx.tx_en) && mii_rx.rxd == $past(mii_tx.txd);
	endproperty
	property p_pwr_line;
		!led_oe_n || (twisted_pair_tx_oe_n && mii_oe_n);
	endproperty
	property p_iso_tx;
		mii_oe_n |-> core_tx == '0;
	endproperty
	property p_loop_sel;
		!(loop_10 && loop_100);
	endproperty
	property p_loop_line;
		(loop_10 || loop_100) |-> twisted_pair_tx_oe_n;
	endproperty
	property p_restart;
		an_restart_pulse |-> an_enable ##1 !an_restart_pulse;
	endproperty
	property p_an_speed;
		s_neg_held |-> link_speed_100 == $past(an_speed_100);
	endproperty
	property p_an_duplex;
		s_neg_held |-> link_full_duplex == $past(an_full_duplex);
	endproperty
	property p_srst_len;
		srst_run <= SRST_CYCLES + 2;
	endproperty
	a_loop_echo: assert property (p_loop_echo) else $error("loopback echo wrong");
	a_pwr_line: assert property (p_pwr_line) else $error("powerdown not tristated");
	a_iso_tx: assert property (p_iso_tx) else $error("isolated tx leaks");
	a_loop_sel: assert property (p_loop_sel) else $error("both loop paths");
	a_loop_line: assert property (p_loop_line) else $error("line driven in loop");
	a_restart: assert property (p_restart) else $error("restart pulse wrong");
	a_an_speed: assert property (p_an_speed) else $error("negotiated speed wrong");
	a_an_duplex: assert property (p_an_duplex) else $error("negotiated duplex wrong");
	a_srst_len: assert property (p_srst_len) else $error("soft reset too long");
endmodule

bind pbcr_basic_control pbcr_basic_control_monitor #(.SRST_CYCLES(SRST_CYCLES))
	pbcr_basic_control_monitor_inst (.*);

// >>> bench/pbcr_mdio_master.sv
`timescale 1ns/1ps
module pbcr_mdio_master (
	// Clock
	input  wire logic clk_sys,
	// Management line
	input  wire logic mdio_out,
	input  wire logic mdio_oe_n,
	output      logic mdc,
	output      logic mdio_in
);
	// ==========================================================================
	// Frame driver
	// ==========================================================================
	logic m_en = 1'b0;
	logic m_bit = 1'b1;
	initial mdc = 1'b0;
	// A released line floats high through the pull-up, never the last bit.
	assign mdio_in = !mdio_oe_n ? mdio_out : (m_en ? m_bit : 1'b1);
	task automatic xfer(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
			input logic [15:0] wd, output logic [15:0] rdv);
		logic [31:0] fr;
		fr = {2'b01, rd ? pbcr_pkg::MGMT_OP_READ : pbcr_pkg::MGMT_OP_WRITE, phy, ra, 2'b10, wd};
		rdv = '0;
		for (int i = 31; i >= 0; i--) begin
			@(negedge clk_sys);
			mdc = 1'b0;
			m_en = !rd || i > 17;
			m_bit = fr[i];
			@(negedge clk_sys);
			if (i < 16) rdv[i] = mdio_in;
			@(negedge clk_sys);
			mdc = 1'b1;
			@(negedge clk_sys);
		end
		@(negedge clk_sys);
		mdc = 1'b0;
		m_en = 1'b0;
	endtask
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin error_cnt++; \
	$display("wrong value %s exp %h got %h", nm, ex, gt); end end
module tb;
	// ==========================================================================
	// Bench
	// ==========================================================================
	localparam int SRST = 200;
	logic clk_sys = 0, rst_n = 0, an_complete = 0, an_speed_100 = 0, an_full_duplex = 0;
	logic [3:0] strap = '0;
	logic [4:0] phy = 5'h01;
	logic mdc, mdio_in, mdio_out, mdio_oe_n, an_enable, an_restart_pulse, soft_reset_active;
	logic link_speed_100, link_full_duplex, mii_oe_n, loop_10, loop_100;
	logic twisted_pair_tx_oe_n, led_oe_n, chk_loop = 0, chk_pass = 0, lp_col = 0;
	logic [15:0] exp_reg, rv;
	logic [3:0] rows [6] = '{4'b0100, 4'b0011, 4'b0010, 4'b0001, 4'b0000, 4'b1000};
	pbcr_pkg::pbcr_mii_tx_t mii_tx = '0, core_tx;
	pbcr_pkg::pbcr_mii_rx_t mii_rx, core_rx = '0;
	int error_cnt = 0, n_compared = 0;
	always #12.5 clk_sys = ~clk_sys;
	pbcr_basic_control #(.SRST_CYCLES(SRST)) pbcr_basic_control_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .autoneg_strap(strap[3]),
		.fast_full_duplex_strap(strap[2]), .fast_half_duplex_strap(strap[1]),
		.slow_full_duplex_strap(strap[0]), .phy_addr_strap(phy), .mdc(mdc),
		.mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
		.an_complete(an_complete), .an_speed_100(an_speed_100),
		.an_full_duplex(an_full_duplex), .an_enable(an_enable),
		.an_restart_pulse(an_restart_pulse), .soft_reset_active(soft_reset_active),
		.link_speed_100(link_speed_100), .link_full_duplex(link_full_duplex),
		.mii_tx(mii_tx), .mii_rx(mii_rx), .mii_oe_n(mii_oe_n), .core_rx(core_rx),
		.core_tx(core_tx), .loop_10(loop_10), .loop_100(loop_100),
		.twisted_pair_tx_oe_n(twisted_pair_tx_oe_n), .led_oe_n(led_oe_n));
	pbcr_mdio_master pbcr_mdio_master_inst (.clk_sys(clk_sys), .mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_in(mdio_in));
	function automatic logic [15:0] dflt(input logic [3:0] s, input logic [4:0] a);
		logic [15:0] v;
		v = '0;
		v[12] = s[3];
		v[13] = s[3] | s[2] | s[1];
		v[10] = (a == 5'h00);
		v[8] = !s[3] && (s[2] || s[0]);
		return v;
	endfunction
	task automatic wr(input logic [15:0] d);
		logic [15:0] v;
		pbcr_mdio_master_inst.xfer(1'b0, phy, 5'h00, d, v);
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic rd_chk(input logic [15:0] ex);
		logic [15:0] v;
		pbcr_mdio_master_inst.xfer(1'b1, phy, 5'h00, 16'h0000, v);
		`CHK("basic_mode_control", ex, v)
	endtask
	task automatic hw_reset;
		rst_n = 0;
		repeat (8) @(negedge clk_sys);
		rst_n = 1;
		repeat (3) @(negedge clk_sys);
	endtask
	task close_out;
		if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Outputs are registered, so at a falling edge they reflect the inputs now present.
	always @(negedge clk_sys) begin
		if (chk_loop) begin
			`CHK("rx_dv", mii_tx.tx_en, mii_rx.rx_dv)
			`CHK("rxd", mii_tx.txd, mii_rx.rxd)
			`CHK("rx_er", mii_tx.tx_er, mii_rx.rx_er)
			`CHK("crs", mii_tx.tx_en, mii_rx.crs)
			`CHK("col", mii_tx.tx_en & lp_col, mii_rx.col)
			`CHK("loop_100", exp_reg[13], loop_100)
			`CHK("loop_10", !exp_reg[13], loop_10)
		end
		if (chk_pass) begin
			`CHK("core_tx", mii_tx, core_tx)
			`CHK("mii_rx", core_rx, mii_rx)
		end
		mii_tx = 6'($urandom);
		core_rx = 10'($urandom);
		an_speed_100 = 1'($urandom);
		an_full_duplex = 1'($urandom);
	end
	initial begin
		#2500000;
		error_cnt++;
		close_out();
	end
	initial begin
		void'($urandom(32'h2edc));
		foreach (rows[i]) begin
			strap = rows[i];
			phy = (i == 5) ? 5'h00 : 5'($urandom_range(31, 1));
			hw_reset();
			rd_chk(dflt(strap, phy));
		end
		strap = 4'b0000;
		phy = 5'h03;
		hw_reset();
		for (int k = 0; k < 4; k++) begin
			exp_reg = 16'($urandom) & 16'h3D80;
			wr(exp_reg);
			rd_chk(exp_reg);
		end
		pbcr_mdio_master_inst.xfer(1'b0, 5'h02, 5'h00, 16'h0800, rv);
		rd_chk(exp_reg);
		pbcr_mdio_master_inst.xfer(1'b1, phy, 5'h01, 16'h0000, rv);
		`CHK("unmapped", 16'hFFFF, rv)
		for (int k = 0; k < 2; k++) begin
			exp_reg = k ? 16'h4000 : 16'h6080;
			lp_col = !k;
			wr(exp_reg);
			chk_loop = 1;
			repeat (20) @(negedge clk_sys);
			chk_loop = 0;
			`CHK("tp_oe_n", 1'b1, twisted_pair_tx_oe_n)
			`CHK("mii_oe_n", 1'b0, mii_oe_n)
		end
		for (int k = 0; k < 2; k++) begin
			wr(k ? 16'h2100 : 16'h0000);
			`CHK("link_speed_100", 1'(k), link_speed_100)
			`CHK("link_full_duplex", 1'(k), link_full_duplex)
		end
		chk_pass = 1;
		repeat (20) @(negedge clk_sys);
		chk_pass = 0;
		wr(16'h0400);
		`CHK("mii_oe_n", 1'b1, mii_oe_n)
		`CHK("core_tx", 6'h00, core_tx)
		wr(16'h0800);
		`CHK("led_oe_n", 1'b1, led_oe_n)
		`CHK("tp_oe_n", 1'b1, twisted_pair_tx_oe_n)
		hw_reset();
		rd_chk(dflt(strap, phy));
		wr(16'h1200);
		`CHK("an_enable", 1'b1, an_enable)
		rd_chk(16'h1200);
		an_complete = 1;
		@(negedge clk_sys);
		an_complete = 0;
		rd_chk(16'h1000);
		wr(16'h0200);
		rd_chk(16'h0000);
		strap = 4'b0010;
		wr(16'h8000);
		`CHK("soft_reset_active", 1'b1, soft_reset_active)
		rd_chk(16'h8000);
		for (int w = 0; w < 400 && soft_reset_active; w++) @(negedge clk_sys);
		if (soft_reset_active !== 1'b0) error_cnt++;
		repeat (2) @(negedge clk_sys);
		rd_chk(dflt(strap, phy));
		close_out();
	end
endmodule

// >>> src/pbcr_basic_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Reset bit starts whole-device soft reset.
// R2: Soft reset resamples straps, restores defaults.
// R3: Reset completes within 25 us, reads 1.
// R4: Loopback isolates line, returns TX to RX.
// R5: Host enables loopback only with negotiation off.
// R6: Loopback path chosen by negotiation, speed bits.
// R7: Speed bit selects 100/10, ignored under negotiation.
// R8: Speed defaults 1 unless three straps low.
// R9: Negotiation enable defaults from its strap.
// R10: Powerdown tristates line, LEDs, isolates MII.
// R11: Hardware reset clears the powerdown bit.
// R12: Isolate ignores TX, tristates MII outputs.
// R13: Isolate defaults 1 only for address zero.
// R14: Restart negotiation self-clears on completion.
// R15: Duplex bit selects full or half.
// R16: Duplex default from negotiation and duplex straps.
// R17: Collision test echoes TX enable on COL.
// R18: Bits six to zero read zero.
module pbcr_basic_control #(
	parameter int SRST_CYCLES = pbcr_pkg::SRST_CYCLES
) (
	// Clock, reset, enable
	input  wire logic                   clk_sys,
	input  wire logic                   rst_n,
	input  wire logic                   ce,
	// Configuration straps
	input  wire logic                   autoneg_strap,
	input  wire logic                   fast_full_duplex_strap,
	input  wire logic                   fast_half_duplex_strap,
	input  wire logic                   slow_full_duplex_strap,
	input  wire logic [4:0]             phy_addr_strap,
	// Serial management
	input  wire logic                   mdc,
	input  wire logic                   mdio_in,
	output      logic                   mdio_out,
	output      logic                   mdio_oe_n,
	// Autonegotiation engine
	input  wire logic                   an_complete,
	input  wire logic                   an_speed_100,
	input  wire logic                   an_full_duplex,
	output      logic                   an_enable,
	output      logic                   an_restart_pulse,
	// Device mode
	output      logic                   soft_reset_active,
	output      logic                   link_speed_100,
	output      logic                   link_full_duplex,
	// MAC side media-independent interface
	input  wire pbcr_pkg::pbcr_mii_tx_t mii_tx,
	output      pbcr_pkg::pbcr_mii_rx_t mii_rx,
	output      logic                   mii_oe_n,
	// Core side
	input  wire pbcr_pkg::pbcr_mii_rx_t core_rx,
	output      pbcr_pkg::pbcr_mii_tx_t core_tx,
	output      logic                   loop_10,
	output      logic                   loop_100,
	// Line and LEDs
	output      logic                   twisted_pair_tx_oe_n,
	output      logic                   led_oe_n
);

	// A longer soft reset needs a wider countdown counter in the package.
	if (SRST_CYCLES < 1 || SRST_CYCLES >= (1 << pbcr_pkg::SRST_CNT_W)) begin : g_chk
		$error("SRST_CYCLES must lie between 1 and the counter range");
	end

	localparam logic [pbcr_pkg::SRST_CNT_W-1:0] SRST_LOAD =
		pbcr_pkg::SRST_CNT_W'(SRST_CYCLES);
	localparam logic [pbcr_pkg::SRST_CNT_W-1:0] SRST_ONE =
		pbcr_pkg::SRST_CNT_W'(1);

	pbcr_pkg::pbcr_state_t state;
	pbcr_pkg::pbcr_state_t next_state;

	// ==========================================================================
	// Read image of the control register
	// ==========================================================================
	function automatic logic [15:0] ctrl_image(input pbcr_pkg::pbcr_state_t s);
		logic [15:0] v;
		v = '0;
		v[pbcr_pkg::CTRL_RESET_BIT] = (s.srst_cnt != '0);           // [R3]
		v[pbcr_pkg::CTRL_LOOP_BIT] = s.ctrl.loopback;
		v[pbcr_pkg::CTRL_SPEED_BIT] = s.ctrl.speed_100;
		v[pbcr_pkg::CTRL_AN_EN_BIT] = s.ctrl.an_en;
		v[pbcr_pkg::CTRL_PWRDN_BIT] = s.ctrl.powerdown;
		v[pbcr_pkg::CTRL_ISOLATE_BIT] = s.ctrl.isolate;
		v[pbcr_pkg::CTRL_AN_RST_BIT] = s.an_restart;
		v[pbcr_pkg::CTRL_DUPLEX_BIT] = s.ctrl.duplex;
		v[pbcr_pkg::CTRL_COLTST_BIT] = s.ctrl.col_test;
		v[6:0] = pbcr_pkg::CTRL_RSVD_VALUE;                         // [R18]
		return v;
	endfunction

	// ==========================================================================
	// Defaults derived from the latched straps
	// ==========================================================================
	function automatic pbcr_pkg::pbcr_ctrl_t strap_defaults(input pbcr_pkg::pbcr_strap_t p);
		pbcr_pkg::pbcr_ctrl_t c;
		c = '0;
		c.an_en = p.autoneg;                                         // [R9]
		c.speed_100 = p.autoneg | p.fast_full_duplex | p.fast_half_duplex; // [R8]
		c.duplex = ~p.autoneg & (p.fast_full_duplex | p.slow_full_duplex); // [R16]
		c.isolate = (p.phy_addr == 5'h00);                           // [R13]
		return c;
	endfunction

	// ==========================================================================
	// Next state
	// ==========================================================================
	always_comb begin
		logic        rise;
		logic        bit_in;
		logic [11:0] hdr;
		logic [15:0] wdata;
		logic        do_write;
		logic [15:0] img;

		next_state = state;
		// Management clock is sampled as data, so it must stay well below clk_sys.
		rise = mdc & ~state.mdc_q;
		bit_in = mdio_in;
		hdr = {state.shreg[10:0], bit_in};
		wdata = {state.shreg[14:0], bit_in};
		do_write = 1'b0;
		img = ctrl_image(state);
		next_state.mdc_q = mdc;
		next_state.an_restart_pulse = 1'b0;

		// Management frames keep running through a soft reset.     [R12]
		if (rise) begin
			case (state.fsm)
				pbcr_pkg::PBCR_IDLE: begin
					// Preamble ones are optional; the first zero is the start.
					if (!bit_in) begin
						next_state.fsm = pbcr_pkg::PBCR_START;
					end
				end
				pbcr_pkg::PBCR_START: begin
					next_state.bit_cnt = '0;
					next_state.fsm = bit_in ? pbcr_pkg::PBCR_HDR : pbcr_pkg::PBCR_IDLE;
				end
				pbcr_pkg::PBCR_HDR: begin
					next_state.shreg = {state.shreg[14:0], bit_in};
					next_state.bit_cnt = state.bit_cnt + 5'h01;
					if (state.bit_cnt == pbcr_pkg::MGMT_HDR_LAST) begin
						next_state.bit_cnt = '0;
						next_state.is_read = (hdr[11:10] == pbcr_pkg::MGMT_OP_READ);
						next_state.addr_ok = (hdr[9:5] == state.straps.phy_addr) &&
							(hdr[4:0] == pbcr_pkg::CTRL_REG_ADDR);
						if (hdr[11:10] == pbcr_pkg::MGMT_OP_READ ||
							hdr[11:10] == pbcr_pkg::MGMT_OP_WRITE) begin
							next_state.fsm = pbcr_pkg::PBCR_TA;
						end else begin
							next_state.fsm = pbcr_pkg::PBCR_IDLE;
						end
					end
				end
				pbcr_pkg::PBCR_TA: begin
					next_state.bit_cnt = state.bit_cnt + 5'h01;
					if (state.bit_cnt != pbcr_pkg::MGMT_TA_LAST) begin
						if (state.is_read && state.addr_ok) begin
							next_state.mdio_drive = 1'b1;
							next_state.mdio_out = 1'b0;
						end
					end else begin
						next_state.bit_cnt = '0;
						next_state.fsm = pbcr_pkg::PBCR_DATA;
						// The image is taken once here, so the word read back is coherent.
						next_state.shreg = {img[14:0], 1'b0};
						next_state.mdio_out = img[15];
					end
				end
				pbcr_pkg::PBCR_DATA: begin
					next_state.bit_cnt = state.bit_cnt + 5'h01;
					if (state.is_read) begin
						next_state.mdio_out = state.shreg[15];
						next_state.shreg = {state.shreg[14:0], 1'b0};
					end else begin
						// Writes shift over the stale image; only the last 16 bits count.
						next_state.shreg = wdata;
					end
					if (state.bit_cnt == pbcr_pkg::MGMT_DATA_LAST) begin
						next_state.fsm = pbcr_pkg::PBCR_IDLE;
						next_state.mdio_drive = 1'b0;
						next_state.mdio_out = 1'b0;
						do_write = ~state.is_read & state.addr_ok;
					end
				end
				default: begin
					next_state.fsm = pbcr_pkg::PBCR_IDLE;
					next_state.mdio_drive = 1'b0;
				end
			endcase
		end

		// Restart completes; a restart written in the same cycle wins below.
		if (an_complete) begin
			next_state.an_restart = 1'b0;                            // [R14]
		end

		// Register writes; ignored while a soft reset is in progress.
		if (do_write && state.srst_cnt == '0) begin
			if (wdata[pbcr_pkg::CTRL_RESET_BIT]) begin
				next_state.srst_cnt = SRST_LOAD;                     // [R1]
				next_state.ctrl = '0;                                // [R2]
				next_state.an_restart = 1'b0;
			end else begin
				next_state.ctrl.loopback = wdata[pbcr_pkg::CTRL_LOOP_BIT];
				next_state.ctrl.speed_100 = wdata[pbcr_pkg::CTRL_SPEED_BIT];
				next_state.ctrl.an_en = wdata[pbcr_pkg::CTRL_AN_EN_BIT];
				next_state.ctrl.powerdown = wdata[pbcr_pkg::CTRL_PWRDN_BIT];
				next_state.ctrl.isolate = wdata[pbcr_pkg::CTRL_ISOLATE_BIT];
				next_state.ctrl.duplex = wdata[pbcr_pkg::CTRL_DUPLEX_BIT];
				next_state.ctrl.col_test = wdata[pbcr_pkg::CTRL_COLTST_BIT];
				if (wdata[pbcr_pkg::CTRL_AN_RST_BIT] && wdata[pbcr_pkg::CTRL_AN_EN_BIT]) begin
					next_state.an_restart = 1'b1;                    // [R14]
					next_state.an_restart_pulse = 1'b1;              // [R14]
				end
			end
		end

		// Soft reset countdown; the last count resamples the straps.
		if (state.srst_cnt != '0) begin
			next_state.srst_cnt = state.srst_cnt - SRST_ONE;         // [R3]
			if (state.srst_cnt == SRST_ONE) begin
				next_state.load_straps = 1'b1;                       // [R2]
			end
		end

		// Straps are caught one clock after any reset, then decoded.
		if (state.load_straps) begin
			next_state.load_straps = 1'b0;
			next_state.straps.autoneg = autoneg_strap;               // [R2]
			next_state.straps.fast_full_duplex = fast_full_duplex_strap;
			next_state.straps.fast_half_duplex = fast_half_duplex_strap;
			next_state.straps.slow_full_duplex = slow_full_duplex_strap;
			next_state.straps.phy_addr = phy_addr_strap;
			next_state.ctrl = strap_defaults(next_state.straps);
			next_state.an_restart = 1'b0;
		end

		// Effective speed and duplex follow negotiation when it is on.
		if (state.ctrl.an_en) begin
			next_state.eff_speed_100 = an_speed_100;                 // [R7]
			next_state.eff_full_duplex = an_full_duplex;
		end else begin
			next_state.eff_speed_100 = state.ctrl.speed_100;         // [R7]
			next_state.eff_full_duplex = state.ctrl.duplex;          // [R15]
		end
	end

	// ==========================================================================
	// State register
	// ==========================================================================
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= '0;                                             // [R11]
			state.fsm <= pbcr_pkg::PBCR_IDLE;
			state.load_straps <= 1'b1;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	// The line is released whenever this station is not answering a read.
	assign mdio_out = state.mdio_out;
	assign mdio_oe_n = ~state.mdio_drive;
	assign an_enable = state.ctrl.an_en;
	assign an_restart_pulse = state.an_restart_pulse;
	// In the steering block only the core_tx gate follows this level; management keeps running.
	assign soft_reset_active = (state.srst_cnt != '0) | state.load_straps; // [R1]
	assign link_speed_100 = state.eff_speed_100;
	assign link_full_duplex = state.eff_full_duplex;

	// Loopback is only meaningful with negotiation off; the host keeps to that.
	pbcr_mii_steer u_steer (                                         // [R5]
		.clk_sys              (clk_sys),
		.rst_n                (rst_n),
		.ce                   (ce),
		.loopback             (state.ctrl.loopback),
		.isolate              (state.ctrl.isolate),
		.powerdown            (state.ctrl.powerdown),
		.col_test             (state.ctrl.col_test),
		.speed_100            (state.eff_speed_100),
		.soft_reset           (soft_reset_active),
		.mii_tx               (mii_tx),
		.mii_rx               (mii_rx),
		.mii_oe_n             (mii_oe_n),
		.core_rx              (core_rx),
		.core_tx              (core_tx),
		.loop_10              (loop_10),
		.loop_100             (loop_100),
		.twisted_pair_tx_oe_n (twisted_pair_tx_oe_n),
		.led_oe_n             (led_oe_n)
	);

endmodule

// >>> src/pbcr_mii_steer.sv
`timescale 1ns/1ps
module pbcr_mii_steer (
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	// Mode controls
	input  wire logic                  loopback,
	input  wire logic                  isolate,
	input  wire logic                  powerdown,
	input  wire logic                  col_test,
	input  wire logic                  speed_100,
	input  wire logic                  soft_reset,
	// MAC side
	input  wire pbcr_pkg::pbcr_mii_tx_t mii_tx,
	output      pbcr_pkg::pbcr_mii_rx_t mii_rx,
	output      logic                  mii_oe_n,
	// Core side
	input  wire pbcr_pkg::pbcr_mii_rx_t core_rx,
	output      pbcr_pkg::pbcr_mii_tx_t core_tx,
	output      logic                  loop_10,
	output      logic                  loop_100,
	// Line and LEDs
	output      logic                  twisted_pair_tx_oe_n,
	output      logic                  led_oe_n
);

	pbcr_pkg::pbcr_steer_state_t state;
	pbcr_pkg::pbcr_steer_state_t next_state;
	logic                        quiet;

	// ==========================================================================
	// Steering
	// ==========================================================================
	always_comb begin
		next_state = state;
		quiet = isolate | powerdown;
		next_state.isolate = quiet;                                  // [R12]
		next_state.pwrdn = powerdown;                                // [R10]
		next_state.loop_100 = loopback & speed_100;                  // [R6]
		next_state.loop_10 = loopback & ~speed_100;                  // [R6]
		// Transmit inputs are ignored while isolated or held in soft reset.
		if (quiet || soft_reset) begin
			next_state.core_tx = '0;                                 // [R12]
		end else begin
			next_state.core_tx = mii_tx;
		end
		if (loopback) begin
			next_state.rx.rxd = mii_tx.txd;                          // [R4]
			next_state.rx.rx_dv = mii_tx.tx_en;                      // [R4]
			next_state.rx.rx_er = mii_tx.tx_er;                      // [R4]
			next_state.rx.crs = mii_tx.tx_en;
			next_state.rx.col = 1'b0;
		end else begin
			next_state.rx.rxd = core_rx.rxd;
			next_state.rx.rx_dv = core_rx.rx_dv;
			next_state.rx.rx_er = core_rx.rx_er;
			next_state.rx.crs = core_rx.crs;
			next_state.rx.col = core_rx.col;
		end
		if (col_test && mii_tx.tx_en) begin
			next_state.rx.col = 1'b1;                                // [R17]
		end
		next_state.rx.tx_clk = core_rx.tx_clk;
		next_state.rx.rx_clk = core_rx.rx_clk;
		if (quiet) begin
			next_state.rx = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= '0;
		end else if (ce) begin
			state <= next_state;
		end
	end

	assign mii_rx = state.rx;
	assign core_tx = state.core_tx;
	assign loop_10 = state.loop_10;
	assign loop_100 = state.loop_100;
	assign mii_oe_n = state.isolate;                                 // [R12]
	// Line driver is released in loopback so no frame leaks onto the cable.
	assign twisted_pair_tx_oe_n = state.pwrdn | state.loop_10 | state.loop_100; // [R4]
	assign led_oe_n = state.pwrdn;                                   // [R10]

endmodule

// >>> src/pbcr_pkg.sv
package pbcr_pkg;

	// ==========================================================================
	// Control register layout
	// ==========================================================================
	localparam logic [4:0] CTRL_REG_ADDR    = 5'h00;
	localparam int         CTRL_RESET_BIT   = 15;
	localparam int         CTRL_LOOP_BIT    = 14;
	localparam int         CTRL_SPEED_BIT   = 13;
	localparam int         CTRL_AN_EN_BIT   = 12;
	localparam int         CTRL_PWRDN_BIT   = 11;
	localparam int         CTRL_ISOLATE_BIT = 10;
	localparam int         CTRL_AN_RST_BIT  = 9;
	localparam int         CTRL_DUPLEX_BIT  = 8;
	localparam int         CTRL_COLTST_BIT  = 7;
	localparam logic [6:0] CTRL_RSVD_VALUE  = 7'h00;

	// ==========================================================================
	// Management frame
	// ==========================================================================
	localparam logic [1:0] MGMT_OP_READ   = 2'h2;
	localparam logic [1:0] MGMT_OP_WRITE  = 2'h1;
	localparam logic [4:0] MGMT_HDR_LAST  = 5'h0B;
	localparam logic [4:0] MGMT_DATA_LAST = 5'h0F;
	localparam logic [4:0] MGMT_TA_LAST   = 5'h01;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int CLK_PERIOD_NS    = 25;
	localparam int SRST_TIME_US     = 25;
	localparam int SRST_CYCLES      = (SRST_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int SRST_CNT_W       = 10;

	// ==========================================================================
	// Types
	// ==========================================================================
	typedef enum logic [4:0] {
		PBCR_IDLE  = 5'h01,
		PBCR_START = 5'h02,
		PBCR_HDR   = 5'h04,
		PBCR_TA    = 5'h08,
		PBCR_DATA  = 5'h10
	} pbcr_fsm_t;

	typedef struct packed {
		logic loopback;
		logic speed_100;
		logic an_en;
		logic powerdown;
		logic isolate;
		logic duplex;
		logic col_test;
	} pbcr_ctrl_t;

	typedef struct packed {
		logic       autoneg;
		logic       fast_full_duplex;
		logic       fast_half_duplex;
		logic       slow_full_duplex;
		logic [4:0] phy_addr;
	} pbcr_strap_t;

	typedef struct packed {
		logic [3:0] txd;
		logic       tx_en;
		logic       tx_er;
	} pbcr_mii_tx_t;

	typedef struct packed {
		logic [3:0] rxd;
		logic       rx_dv;
		logic       rx_er;
		logic       col;
		logic       crs;
		logic       tx_clk;
		logic       rx_clk;
	} pbcr_mii_rx_t;

	typedef struct packed {
		pbcr_fsm_t               fsm;
		logic                    mdc_q;
		logic [4:0]              bit_cnt;
		logic [15:0]             shreg;
		logic                    is_read;
		logic                    addr_ok;
		logic                    mdio_out;
		logic                    mdio_drive;
		pbcr_ctrl_t              ctrl;
		logic                    an_restart;
		logic                    an_restart_pulse;
		logic [SRST_CNT_W-1:0]   srst_cnt;
		logic                    load_straps;
		pbcr_strap_t             straps;
		logic                    eff_speed_100;
		logic                    eff_full_duplex;
	} pbcr_state_t;

	typedef struct packed {
		logic [3:0] txd;
		logic       tx_en;
		logic       tx_er;
		logic       loop_10;
		logic       loop_100;
		logic       isolate;
		logic       pwrdn;
		pbcr_mii_rx_t rx;
		pbcr_mii_tx_t core_tx;
	} pbcr_steer_state_t;

endpackage
